// file: logic/ies_defs.vh
`ifndef IES_DEFS_VH
`define IES_DEFS_VH

// i/o space addresses of the block's registers
`define IES_IO_IRQ_EN 6'h30
`define IES_IO_IRQ_FLAG 6'h31
`define IES_IO_GENERAL_IRQ_CONTROL 6'h3b
`define IES_IO_SPL 6'h3d
`define IES_IO_SPH 6'h3e
`define IES_IO_FLAGS 6'h3f

// field positions
`define IES_GIE_BIT 7
`define IES_VECTOR_RELOCATE_SELECT_BIT 1

// reset values
`define IES_SP_RESET 16'h0000
`define IES_FLAGS_RESET 8'h00
`define IES_GENERAL_IRQ_CONTROL_RESET 8'h00
`define IES_EN_RESET 4'h0

// program space layout
`define IES_PC_ZERO 12'h000
`define IES_BOOT_START 12'hc00

// interrupt channels; set bits mark condition-type channels
`define IES_NCH 4
`define IES_COND_MASK 4'b1100

// cycle counts (last count of each phase)
`define IES_ENTRY_LAST 3'd3
`define IES_WAKE_LAST 3'd3
`define IES_RET_LAST 3'd3

// sequencer states
`define IES_ST_IDLE 2'd0
`define IES_ST_WAKE 2'd1
`define IES_ST_ENTRY 2'd2
`define IES_ST_RETN 2'd3

`endif

// file: logic/ies_sp.v
`default_nettype none
`include "ies_defs.vh"

module ies_sp (
  input wire mclk,
  input wire reset,
  input wire wr_hi,
  input wire wr_lo,
  input wire [7:0] wdata,
  input wire dec1,
  input wire dec2,
  input wire inc1,
  input wire inc2,
  output reg [15:0] stack_top_pointer
);

  reg [15:0] next_sp;

  ////////////////////////////////////////////////////////////////////////////
  // software writes win over stack adjustments in the same cycle
  always @* begin
    next_sp = stack_top_pointer;
    if (dec1) begin
      next_sp = stack_top_pointer - 16'h0001;
    end else if (dec2) begin
      next_sp = stack_top_pointer - 16'h0002;
    end else if (inc1) begin
      next_sp = stack_top_pointer + 16'h0001;
    end else if (inc2) begin
      next_sp = stack_top_pointer + 16'h0002;
    end
    if (wr_hi) begin
      next_sp[15:8] = wdata;
    end
    if (wr_lo) begin
      next_sp[7:0] = wdata;
    end
  end

  always @(posedge mclk) begin
    if (reset) begin
      stack_top_pointer <= `IES_SP_RESET;
    end else begin
      stack_top_pointer <= next_sp;
    end
  end

endmodule // ies_sp

`default_nettype wire

// file: logic/ies_prio.v
`default_nettype none
`include "ies_defs.vh"

module ies_prio (
  input wire [3:0] req,
  output wire any,
  output reg [1:0] idx
);

  wire [4:0] blocked;
  wire [3:0] grant;
  integer k;

  assign blocked[0] = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // lowest index wins
  genvar i;
  generate
    for (i = 0; i < `IES_NCH; i = i + 1) begin : g_chain
      assign grant[i] = req[i] & ~blocked[i];
      assign blocked[i + 1] = blocked[i] | req[i];
    end
  endgenerate

  assign any = blocked[`IES_NCH];

  always @* begin
    idx = 2'b00;
    for (k = 0; k < `IES_NCH; k = k + 1) begin
      if (grant[k]) begin
        idx = k[1:0];
      end
    end
  end

endmodule // ies_prio

`default_nettype wire

// file: logic/ies_core.v
// What this block does
// - stack grows downward; pointer marks current top, pushes lower it.
// - single-byte push lowers pointer by one, return-address push by two.
// - single-byte pop raises pointer by one, return-address pop by two.
// - pointer is two 8-bit read/write i/o registers, both zero at reset.
// - block runs straight on the core clock, no internal division.
// - read, compute and write back of state happen within one clock.
// - interrupt taken only when its own enable and global enable are set.
// - programmed boot lock bits suppress interrupts depending on program counter.
// - vectors sit at lowest addresses; lower vector means higher priority.
// - vector-select bit moves vectors to boot start; fuse moves reset vector.
// - entry clears global enable; software may set it; handler return sets it.
// - flag cleared by hardware on vectoring, and by writing one to it.
// - flags stay pending while disabled, then serviced in priority order.
// - condition interrupts request only while condition is present.
// - after handler return one interrupted instruction runs before next entry.
// - flags register is neither saved nor restored on entry or return.
// - clearing global enable acts at once, even against same-cycle requests.
// - after setting global enable the next instruction runs before any entry.
// - entry takes four cycles pushing the program counter before the vector.
// - a multi-cycle instruction completes before entry starts.
// - entry from sleep takes four extra cycles.
// - handler return takes four cycles: pops counter, pointer plus two, sets enable.
// - global enable sits in bit 7 of the flags register.
`default_nettype none
`include "ies_defs.vh"

module ies_core (
  input wire mclk,
  input wire reset,
  input wire [5:0] io_addr,
  input wire io_we,
  input wire io_re,
  input wire [7:0] io_wdata,
  output reg [7:0] io_rdata,
  input wire instr_done,
  input wire op_sei,
  input wire op_cli,
  input wire op_return_from_handler,
  input wire sp_push1,
  input wire sp_pop1,
  input wire sp_call2,
  input wire sp_ret2,
  input wire sleeping,
  input wire [11:0] pc,
  input wire [3:0] src_event,
  input wire [3:0] src_level,
  input wire boot_lock_bit_app,
  input wire boot_lock_bit_boot,
  input wire reset_vector_relocate_fuse,
  output reg [15:0] stack_addr,
  output reg [7:0] stack_wdata,
  output reg stack_we,
  output reg stack_re,
  input wire [7:0] stack_rdata,
  output wire entry_busy,
  output reg vector_valid,
  output reg [11:0] vector_addr,
  output reg ret_valid,
  output reg [11:0] ret_pc,
  output reg [11:0] reset_vector,
  output wire global_enable
);

  reg [7:0] cpu_flags_register;
  reg [7:0] general_irq_control;
  reg [3:0] irq_enable;
  reg [3:0] irq_flag;
  reg [1:0] state;
  reg [2:0] cnt;
  reg [1:0] taken_idx;
  reg [11:0] saved_pc;
  reg [3:0] ret_hi;
  reg [1:0] next_state;
  reg [2:0] next_cnt;
  reg [3:0] next_flag;
  wire [15:0] stack_top_pointer;
  wire [3:0] req;
  wire req_any;
  wire [1:0] req_idx;
  wire gie;
  wire vector_relocate_select;
  wire wr_flags;
  wire wr_general_irq_control;
  wire wr_en;
  wire wr_flag;
  wire boundary;
  wire lock_block;
  wire take;
  wire entry_done;
  wire ret_done;
  wire [3:0] hw_clear;
  wire [2:0] idx_p1;

  ////////////////////////////////////////////////////////////////////////////
  // register decode

  assign wr_flags = io_we & (io_addr == `IES_IO_FLAGS);
  assign wr_general_irq_control = io_we & (io_addr == `IES_IO_GENERAL_IRQ_CONTROL);
  assign wr_en = io_we & (io_addr == `IES_IO_IRQ_EN);
  assign wr_flag = io_we & (io_addr == `IES_IO_IRQ_FLAG);

  assign gie = cpu_flags_register[`IES_GIE_BIT];
  assign vector_relocate_select = general_irq_control[`IES_VECTOR_RELOCATE_SELECT_BIT];
  assign global_enable = gie;

  ////////////////////////////////////////////////////////////////////////////
  // stack pointer

  ies_sp u_sp (
    .mclk(mclk),
    .reset(reset),
    .wr_hi(io_we & (io_addr == `IES_IO_SPH)),
    .wr_lo(io_we & (io_addr == `IES_IO_SPL)),
    .wdata(io_wdata),
    .dec1(sp_push1),
    .dec2(sp_call2 | entry_done),
    .inc1(sp_pop1),
    .inc2(sp_ret2 | ret_done),
    .stack_top_pointer(stack_top_pointer)
  );

  ////////////////////////////////////////////////////////////////////////////
  // request gathering

  // condition channels follow the live level
  assign req = ((irq_flag & ~`IES_COND_MASK) | (src_level & `IES_COND_MASK)) & irq_enable;

  ies_prio u_prio (
    .req(req),
    .any(req_any),
    .idx(req_idx)
  );

  // boot lock suppression by program counter
  assign lock_block = (boot_lock_bit_app & (pc < `IES_BOOT_START) & vector_relocate_select) |
                      (boot_lock_bit_boot & (pc >= `IES_BOOT_START) & ~vector_relocate_select);

  // entry only at an instruction boundary
  // boundary after return is that of the next instruction
  // the enable set by the current instruction is not yet seen here
  assign boundary = instr_done | sleeping;

  // cli in the same cycle blocks the take
  assign take = (state == `IES_ST_IDLE) & boundary & gie & ~op_cli & ~op_return_from_handler &
                req_any & ~lock_block;

  assign entry_done = (state == `IES_ST_ENTRY) & (cnt == `IES_ENTRY_LAST);
  assign ret_done = (state == `IES_ST_RETN) & (cnt == `IES_RET_LAST);
  assign entry_busy = (state != `IES_ST_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // flag bits

  genvar c;
  generate
    for (c = 0; c < `IES_NCH; c = c + 1) begin : g_clr
      assign hw_clear[c] = take & (req_idx == c);
    end
  endgenerate

  always @* begin
    next_flag = irq_flag & ~hw_clear;
    if (wr_flag) begin
      next_flag = next_flag & ~io_wdata[3:0];
    end
    // a new event wins over any clear
    next_flag = (next_flag | src_event) & ~`IES_COND_MASK;
  end

  always @(posedge mclk) begin
    if (reset) begin
      irq_flag <= 4'h0;
    end else begin
      irq_flag <= next_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers

  // single clock domain on the core clock
  always @(posedge mclk) begin
    if (reset) begin
      cpu_flags_register <= `IES_FLAGS_RESET;
      general_irq_control <= `IES_GENERAL_IRQ_CONTROL_RESET;
      irq_enable <= `IES_EN_RESET;
    end else begin
      if (wr_general_irq_control) begin
        general_irq_control <= io_wdata;
      end
      if (wr_en) begin
        irq_enable <= io_wdata[3:0];
      end
      // only the enable bit is touched by hardware
      if (wr_flags) begin
        cpu_flags_register <= io_wdata;
      end
      if (op_sei) begin
        cpu_flags_register[`IES_GIE_BIT] <= 1'b1;
      end
      if (op_cli) begin
        cpu_flags_register[`IES_GIE_BIT] <= 1'b0;
      end
      if (take) begin
        cpu_flags_register[`IES_GIE_BIT] <= 1'b0;
      end
      if (ret_done) begin
        cpu_flags_register[`IES_GIE_BIT] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // entry and return sequencer

  always @* begin
    next_state = state;
    next_cnt = cnt + 3'd1;
    case (state)
      `IES_ST_IDLE: begin
        next_cnt = 3'd0;
        if (take) begin
          next_state = sleeping ? `IES_ST_WAKE : `IES_ST_ENTRY;
        end else if (op_return_from_handler) begin
          next_state = `IES_ST_RETN;
        end
      end
      `IES_ST_WAKE: begin
        if (cnt == `IES_WAKE_LAST) begin
          next_state = `IES_ST_ENTRY;
          next_cnt = 3'd0;
        end
      end
      `IES_ST_ENTRY: begin
        if (entry_done) begin
          next_state = `IES_ST_IDLE;
          next_cnt = 3'd0;
        end
      end
      `IES_ST_RETN: begin
        if (ret_done) begin
          next_state = `IES_ST_IDLE;
          next_cnt = 3'd0;
        end
      end
      default: begin
        next_state = `IES_ST_IDLE;
        next_cnt = 3'd0;
      end
    endcase
  end

  // state read, computed and stored each clock
  always @(posedge mclk) begin
    if (reset) begin
      state <= `IES_ST_IDLE;
      cnt <= 3'd0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stack memory port, vector and return address

  assign idx_p1 = {1'b0, taken_idx} + 3'd1;

  always @(posedge mclk) begin
    if (reset) begin
      stack_addr <= 16'h0000;
      stack_wdata <= 8'h00;
      stack_we <= 1'b0;
      stack_re <= 1'b0;
      taken_idx <= 2'b00;
      saved_pc <= `IES_PC_ZERO;
      ret_hi <= 4'h0;
      vector_valid <= 1'b0;
      vector_addr <= `IES_PC_ZERO;
      ret_valid <= 1'b0;
      ret_pc <= `IES_PC_ZERO;
    end else begin
      vector_valid <= 1'b0;
      ret_valid <= 1'b0;
      stack_we <= 1'b0;
      stack_re <= 1'b0;
      // counter pushed low byte then high byte
      // first byte goes at the current top, second one below it
      if (take) begin
        taken_idx <= req_idx;
        saved_pc <= pc;
        stack_we <= ~sleeping;
        stack_addr <= stack_top_pointer;
        stack_wdata <= pc[7:0];
      end
      if ((state == `IES_ST_WAKE) & (cnt == `IES_WAKE_LAST)) begin
        stack_we <= 1'b1;
        stack_addr <= stack_top_pointer;
        stack_wdata <= saved_pc[7:0];
      end
      if ((state == `IES_ST_ENTRY) & (cnt == 3'd0)) begin
        stack_we <= 1'b1;
        stack_addr <= stack_top_pointer - 16'h0001;
        stack_wdata <= {4'h0, saved_pc[11:8]};
      end
      if (entry_done) begin
        vector_valid <= 1'b1;
        vector_addr <= (vector_relocate_select ? `IES_BOOT_START : `IES_PC_ZERO) + {9'h000, idx_p1};
      end
      // pop high byte then low byte
      if ((state == `IES_ST_IDLE) & op_return_from_handler & ~take) begin
        stack_re <= 1'b1;
        stack_addr <= stack_top_pointer + 16'h0001;
      end
      if ((state == `IES_ST_RETN) & (cnt == 3'd0)) begin
        stack_re <= 1'b1;
        stack_addr <= stack_top_pointer + 16'h0002;
      end
      if ((state == `IES_ST_RETN) & (cnt == 3'd1)) begin
        ret_hi <= stack_rdata[3:0];
      end
      if ((state == `IES_ST_RETN) & (cnt == 3'd2)) begin
        ret_pc <= {ret_hi, stack_rdata};
      end
      if (ret_done) begin
        ret_valid <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset vector and register reads

  // reset vector at the lowest address by default
  always @(posedge mclk) begin
    if (reset) begin
      reset_vector <= `IES_PC_ZERO;
    end else begin
      reset_vector <= reset_vector_relocate_fuse ? `IES_BOOT_START : `IES_PC_ZERO;
    end
  end

  always @(posedge mclk) begin
    if (reset) begin
      io_rdata <= 8'h00;
    end else if (io_re) begin
      case (io_addr)
        `IES_IO_SPL: io_rdata <= stack_top_pointer[7:0];
        `IES_IO_SPH: io_rdata <= stack_top_pointer[15:8];
        `IES_IO_FLAGS: io_rdata <= cpu_flags_register;
        `IES_IO_GENERAL_IRQ_CONTROL: io_rdata <= general_irq_control;
        `IES_IO_IRQ_EN: io_rdata <= {4'h0, irq_enable};
        `IES_IO_IRQ_FLAG: io_rdata <= {4'h0, irq_flag};
        default: io_rdata <= 8'h00;
      endcase
    end
  end

endmodule // ies_core

`default_nettype wire

// file: dv/ies_core_properties.sv
`default_nettype none
module ies_core_checker (
  input wire logic mclk,
  input wire logic reset,
  input wire logic op_cli,
  input wire logic op_return_from_handler,
  input wire logic sleeping,
  input wire logic [15:0] stack_addr,
  input wire logic stack_we,
  input wire logic stack_re,
  input wire logic entry_busy,
  input wire logic vector_valid,
  input wire logic ret_valid,
  input wire logic global_enable
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  property p_push_desc;
    stack_we && !$past(stack_we) |=> stack_we && (stack_addr == $past(stack_addr) - 16'h0001);
  endproperty
  a_push_desc: assert property (p_push_desc)
    else $error("return address push does not step down");
  property p_pop_asc;
    stack_re && !$past(stack_re) |=> stack_re && (stack_addr == $past(stack_addr) + 16'h0001);
  endproperty
  a_pop_asc: assert property (p_pop_asc)
    else $error("return address pop does not step up");
  property p_entry_gie;
    stack_we |-> !global_enable;
  endproperty
  a_entry_gie: assert property (p_entry_gie)
    else $error("global enable still set during entry");
  property p_vec_pulse;
    vector_valid |=> !vector_valid;
  endproperty
  a_vec_pulse: assert property (p_vec_pulse)
    else $error("vector strobe longer than one cycle");
  property p_entry_len;
    vector_valid && !$past(sleeping, 9) |-> $past(stack_we, 4) && $past(stack_we, 3);
  endproperty
  a_entry_len: assert property (p_entry_len)
    else $error("entry length wrong");
  property p_ret_len;
    ret_valid |-> $past(stack_re, 4) && $past(stack_re, 3) && global_enable;
  endproperty
  a_ret_len: assert property (p_ret_len)
    else $error("return length or enable wrong");
  property p_cli_now;
    op_cli && !entry_busy && !op_return_from_handler |=> !entry_busy;
  endproperty
  a_cli_now: assert property (p_cli_now)
    else $error("entry taken with clear of enable");
  property p_gie_gate;
    !global_enable && !entry_busy && !op_return_from_handler |=> !entry_busy;
  endproperty
  a_gie_gate: assert property (p_gie_gate)
    else $error("entry taken with global enable off");
endmodule // ies_core_checker

bind ies_core ies_core_checker u_chk (.mclk, .reset, .op_cli, .op_return_from_handler, .sleeping, .stack_addr,
  .stack_we, .stack_re, .entry_busy, .vector_valid, .ret_valid, .global_enable);
`default_nettype wire

// file: dv/ies_stack_mem.sv
`default_nettype none
module ies_stack_mem (
  input wire logic mclk,
  input wire logic [15:0] stack_addr,
  input wire logic [7:0] stack_wdata,
  input wire logic stack_we,
  input wire logic stack_re,
  output logic [7:0] stack_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [0:2047];
  initial stack_rdata = 8'h00;
  // read data is good in the cycle after a read, then inverts on each idle cycle, so a stale byte is wrong every other cycle
  always @(posedge mclk) begin
    if (stack_we)
      mem[stack_addr[10:0]] <= stack_wdata;
    stack_rdata <= stack_re ? mem[stack_addr[10:0]] : ~stack_rdata;
  end
endmodule // ies_stack_mem
`default_nettype wire

// file: dv/ies_core_tb_top.sv
`default_nettype none
module ies_core_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 0, reset = 1, io_we = 0, io_re = 0, instr_done = 0, op_sei = 0, op_cli = 0;
  logic op_return_from_handler = 0, sp_push1 = 0, sp_pop1 = 0, sp_call2 = 0, sp_ret2 = 0, sleeping = 0;
  logic boot_lock_bit_app = 0, boot_lock_bit_boot = 0, reset_vector_relocate_fuse = 0;
  logic [5:0] io_addr = 6'h00;
  logic [7:0] io_wdata = 8'h00;
  logic [11:0] pc = 12'h2a5;
  logic [3:0] src_event = 4'h0, src_level = 4'h0;
  logic [7:0] io_rdata, stack_wdata, stack_rdata;
  logic [15:0] stack_addr;
  logic stack_we, stack_re, entry_busy, vector_valid, ret_valid, global_enable;
  logic [11:0] vector_addr, ret_pc, reset_vector;
  int err_total = 0, n_checks = 0;

  ies_core u_dut (.mclk, .reset, .io_addr, .io_we, .io_re, .io_wdata, .io_rdata, .instr_done,
    .op_sei, .op_cli, .op_return_from_handler, .sp_push1, .sp_pop1, .sp_call2, .sp_ret2, .sleeping, .pc,
    .src_event, .src_level, .boot_lock_bit_app, .boot_lock_bit_boot, .reset_vector_relocate_fuse,
    .stack_addr, .stack_wdata, .stack_we, .stack_re, .stack_rdata, .entry_busy, .vector_valid,
    .vector_addr, .ret_valid, .ret_pc, .reset_vector, .global_enable);
  ies_stack_mem u_mem (.mclk, .stack_addr, .stack_wdata, .stack_we, .stack_re, .stack_rdata);

  always #12.5 mclk = ~mclk;

  ////////////////////////////////////////////////////////////////////////////////
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [5:0] a, input logic [7:0] v);
    @(posedge mclk);
    io_addr <= a;
    io_wdata <= v;
    io_we <= 1'b1;
    @(posedge mclk);
    io_we <= 1'b0;
  endtask
  task rd(input logic [5:0] a, input logic [7:0] v);
    @(posedge mclk);
    io_addr <= a;
    io_re <= 1'b1;
    @(posedge mclk);
    io_re <= 1'b0;
    #1;
    chk(io_rdata, v);
  endtask
  // one-cycle strobes: done, sei, cli, return_from_handler, push1, pop1, call2, ret2
  task pulse(input logic [7:0] m);
    @(posedge mclk);
    {instr_done, op_sei, op_cli, op_return_from_handler, sp_push1, sp_pop1, sp_call2, sp_ret2} <= m;
    @(posedge mclk);
    {instr_done, op_sei, op_cli, op_return_from_handler, sp_push1, sp_pop1, sp_call2, sp_ret2} <= 8'h00;
  endtask
  task ev(input logic [3:0] m);
    @(posedge mclk);
    src_event <= m;
    @(posedge mclk);
    src_event <= 4'h0;
  endtask
  task await(input logic rv, input logic [7:0] lat);
    int n;
    n = 0;
    while (n < 20 && (rv ? ret_valid : vector_valid) !== 1'b1) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk(n[7:0], lat);
  endtask
  task take(input logic slp, input logic [7:0] lat, input logic [11:0] vec);
    @(posedge mclk);
    instr_done <= 1'b1;
    sleeping <= slp;
    @(posedge mclk);
    instr_done <= 1'b0;
    sleeping <= 1'b0;
    await(1'b0, lat);
    chk(vector_addr, vec);
    chk(entry_busy, 1'b0);
    chk(global_enable, 1'b0);
  endtask
  task return_from_handler;
    pulse(8'h10);
    await(1'b1, 8'd4);
    chk(ret_pc, pc);
  endtask
  task noentry(input logic [7:0] m);
    logic seen;
    seen = 1'b0;
    pulse(m);
    repeat (8) begin
      @(posedge mclk);
      #1;
      seen = seen | stack_we | vector_valid;
    end
    chk(seen, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task s_reset_regs;
    rd(6'h3d, 8'h00);
    rd(6'h3e, 8'h00);
    rd(6'h3f, 8'h00);
    chk(reset_vector, 12'h000);
    @(posedge mclk);
    reset_vector_relocate_fuse <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    chk(reset_vector, 12'hc00);
  endtask
  task s_stack;
    wr(6'h3e, 8'h04);
    wr(6'h3d, 8'h60);
    pulse(8'h08);
    rd(6'h3d, 8'h5f);
    pulse(8'h04);
    rd(6'h3d, 8'h60);
    pulse(8'h02);
    rd(6'h3d, 8'h5e);
    pulse(8'h01);
    rd(6'h3d, 8'h60);
    rd(6'h3e, 8'h04);
  endtask
  task s_entry;
    wr(6'h30, 8'h03);
    ev(4'h3);
    wr(6'h3f, 8'h83);
    take(1'b0, 8'd4, 12'h001);
    rd(6'h3f, 8'h03);
    rd(6'h31, 8'h02);
    rd(6'h3d, 8'h5e);
    return_from_handler;
    rd(6'h3f, 8'h83);
    rd(6'h3d, 8'h60);
    // no entry straight out of the return, only at the next boundary
    noentry(8'h00);
    take(1'b0, 8'd4, 12'h002);
    return_from_handler;
    rd(6'h31, 8'h00);
    ev(4'h2);
    rd(6'h31, 8'h02);
    wr(6'h31, 8'h02);
    rd(6'h31, 8'h00);
  endtask
  task s_cli;
    ev(4'h1);
    noentry(8'ha0);
    rd(6'h3f, 8'h03);
    noentry(8'hc0);
    take(1'b0, 8'd4, 12'h001);
    return_from_handler;
  endtask
  task s_cond;
    wr(6'h30, 8'h00);
    @(posedge mclk);
    src_level <= 4'h4;
    repeat (3) @(posedge mclk);
    src_level <= 4'h0;
    wr(6'h30, 8'h04);
    noentry(8'h80);
    @(posedge mclk);
    src_level <= 4'h4;
    take(1'b0, 8'd4, 12'h003);
    @(posedge mclk);
    src_level <= 4'h0;
    return_from_handler;
  endtask
  task s_boot;
    wr(6'h30, 8'h01);
    wr(6'h3b, 8'h02);
    ev(4'h1);
    @(posedge mclk);
    boot_lock_bit_app <= 1'b1;
    noentry(8'h80);
    @(posedge mclk);
    boot_lock_bit_app <= 1'b0;
    take(1'b1, 8'd8, 12'hc01);
    return_from_handler;
  endtask

  task end_of_test;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    s_reset_regs;
    s_stack;
    s_entry;
    s_cli;
    s_cond;
    s_boot;
    end_of_test;
  end
  initial begin
    #(25 * 5000);
    err_total++;
    end_of_test;
  end
endmodule // ies_core_tb_top
`default_nettype wire
